/* File: common/dwc_pkg.sv */
package dwc_pkg;
    localparam int NCH = 8;
    localparam int CW = 32;
    localparam int FW = 20;
    localparam int CLK_PERIOD_NS = 5;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [9:0] SEC_MS = 10'h3E8;
    localparam logic [15:0] WDT_OFF_S = 16'h0000;
    localparam logic [15:0] WDT_MIN_S = 16'h0005;
    localparam logic [15:0] PWM_MIN_MS = 16'h0005;
    localparam logic [15:0] PWM_DEF_MS = 16'h03E8;
    localparam logic [9:0] WIN_LONG_MS = 10'h3E8;
    localparam logic [9:0] WIN_SHORT_MS = 10'h064;
    localparam logic [9:0] SCALE_LONG = 10'h064;
    localparam logic [9:0] SCALE_SHORT = 10'h3E8;
    localparam logic [16:0] PULSE_DIVIDEND = 17'h186A0;
    localparam logic [16:0] PERIOD_MAX_MS = 17'h186A0;
    localparam logic [15:0] EDGE_MAX = 16'hFFFF;
    localparam int AVG_DEPTH = 8;

    typedef enum logic [1:0] {
        DWC_SCAN_1000 = 2'b00,
        DWC_SCAN_100 = 2'b01,
        DWC_SCAN_PULSE = 2'b10
    } dwc_scan_t;

    typedef enum logic [1:0] {
        DWC_AVG_1 = 2'b00,
        DWC_AVG_2 = 2'b01,
        DWC_AVG_4 = 2'b10,
        DWC_AVG_8 = 2'b11
    } dwc_avg_t;

    typedef enum logic {
        DWC_DIV_IDLE = 1'b0,
        DWC_DIV_RUN = 1'b1
    } dwc_div_state_t;
endpackage

/* File: rtl/dwc_pwm_chan.sv */
`timescale 1ns/10ps
module dwc_pwm_chan (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Timing
    input wire logic ms_tick,
    input wire logic enable,
    input wire logic [15:0] high_ms,
    input wire logic [15:0] low_ms,
    // Waveform
    output logic level_ff
);
    logic [15:0] cnt_ff;
    logic [15:0] width;

    // Widths under the floor would alias the tick resolution, so they are raised
    always_comb begin
        width = level_ff ? high_ms : low_ms;
        if (width < dwc_pkg::PWM_MIN_MS) begin
            width = dwc_pkg::PWM_MIN_MS;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_ff <= 1'b1;
            cnt_ff <= 16'h0000;
        end else if (!enable) begin
            level_ff <= 1'b1;
            cnt_ff <= 16'h0000;
        end else if (ms_tick) begin
            if (cnt_ff + 16'h0001 >= width) begin
                level_ff <= ~level_ff;
                cnt_ff <= 16'h0000;
            end else begin
                cnt_ff <= cnt_ff + 16'h0001;
            end
        end
    end
endmodule

/* File: rtl/dwc_in_chan.sv */
`timescale 1ns/10ps
module dwc_in_chan (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Synchronised input
    input wire logic level,
    input wire logic rise,
    // Counter control
    input wire logic cnt_en,
    input wire logic cnt_clear,
    input wire logic [dwc_pkg::CW-1:0] preset,
    // Latch control
    input wire logic latch_en,
    input wire logic clr_high,
    input wire logic clr_low,
    // State
    output logic [dwc_pkg::CW-1:0] count_ff,
    output logic latch_high_ff,
    output logic latch_low_ff
);
    logic [dwc_pkg::CW-1:0] step;

    assign step = {{(dwc_pkg::CW-1){1'b0}}, cnt_en & rise};

    // An edge in the clearing cycle is counted on top of the preset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_ff <= '0;
        end else if (cnt_clear) begin
            count_ff <= preset + step;
        end else begin
            count_ff <= count_ff + step;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_high_ff <= 1'b0;
        end else if (latch_en && level) begin
            latch_high_ff <= 1'b1;
        end else if (clr_high) begin
            latch_high_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_low_ff <= 1'b0;
        end else if (latch_en && !level) begin
            latch_low_ff <= 1'b1;
        end else if (clr_low) begin
            latch_low_ff <= 1'b0;
        end
    end
endmodule

/* File: rtl/dwc_top.sv */
`timescale 1ns/10ps
// Overview of operation
// - Watchdog timeout accepts 5 to 65535 seconds; zero disables it.
// - Watchdog expiry drives all outputs to the safe pattern.
// - After reset the outputs load the power-on pattern.
// - Host writes an eight-bit value straight to the outputs.
// - Enable mask chooses which input counters run.
// - Counter clear resets accumulated counts.
// - Each counter keeps a preset used as its start value.
// - Frequency windows of 1000 ms and 100 ms, up to 3.5 kHz.
// - Single-pulse mode measures 0.01 Hz to 1 Hz from one period.
// - Frequency averaged over 1, 2, 4 or 8 samples.
// - One global bit enables high and low input latches.
// - Clear-high control resets all high latch flags, except on high inputs while latching is enabled.
// - Clear-low control resets all low latch flags, except on low inputs while latching is enabled.
// - Per-channel mask enables PWM on each output, default off.
// - Each output has a high width and a low width.
// - Widths in 1 ms units, 5 to 65535 ms, default 1000.
module dwc_top #(
    parameter int MS_CYCLES = dwc_pkg::MS_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Host output control
    input wire logic host_activity,
    input wire logic [15:0] wdt_timeout_s,
    input wire logic [7:0] safe_value,
    input wire logic [7:0] power_on_value,
    input wire logic out_write_stb,
    input wire logic [7:0] out_write_data,
    // Counters and latches
    input wire logic [7:0] cnt_enable,
    input wire logic cnt_clear,
    input wire logic [dwc_pkg::NCH*dwc_pkg::CW-1:0] cnt_preset,
    input wire logic latch_enable,
    input wire logic latch_clr_high,
    input wire logic latch_clr_low,
    // Frequency measurement
    input wire logic [7:0] freq_enable,
    input wire logic [1:0] freq_scan_mode,
    input wire logic [1:0] freq_avg_sel,
    // PWM
    input wire logic [7:0] pwm_enable,
    input wire logic [dwc_pkg::NCH*16-1:0] pwm_high_ms,
    input wire logic [dwc_pkg::NCH*16-1:0] pwm_low_ms,
    // Field wiring
    input wire logic [7:0] input_channel,
    output logic [7:0] output_channel,
    // Status
    output logic wdt_expired,
    output logic [dwc_pkg::NCH*dwc_pkg::CW-1:0] cnt_value,
    output logic [dwc_pkg::NCH*dwc_pkg::FW-1:0] freq_value,
    output logic [7:0] latch_high,
    output logic [7:0] latch_low
);
    localparam int NCH = dwc_pkg::NCH;
    localparam int FW = dwc_pkg::FW;
    localparam int MSW = $clog2(MS_CYCLES + 1);

    if (MS_CYCLES < 1) begin : g_bad_ms
        $error("MS_CYCLES must be at least one");
    end

    logic [1:0] rst_sync_ff;
    logic rst_n_s;
    logic [7:0] in_meta_ff;
    logic [7:0] in_sync_ff;
    logic [7:0] in_prev_ff;
    logic [7:0] in_rise;
    logic [MSW-1:0] ms_cnt_ff;
    logic ms_tick_ff;
    logic [9:0] sec_ms_ff;
    logic sec_tick_ff;
    logic [15:0] wdt_sec_ff;
    logic [15:0] wdt_limit;
    logic wdt_fire;
    logic wdt_expired_ff;
    logic boot_done_ff;
    logic [7:0] out_base_ff;
    logic [7:0] out_ff;
    logic [7:0] pwm_level;
    logic clr_high_prev_ff;
    logic clr_low_prev_ff;
    logic clr_high_pulse;
    logic clr_low_pulse;
    logic [9:0] win_ms_ff;
    logic [9:0] win_len;
    logic [9:0] win_scale;
    logic win_end_ff;

    // Reset is released through two flops so every flop leaves reset together
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n_s = rst_sync_ff[1];

    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            in_meta_ff <= 8'h00;
            in_sync_ff <= 8'h00;
            in_prev_ff <= 8'h00;
        end else begin
            in_meta_ff <= input_channel;
            in_sync_ff <= in_meta_ff;
            in_prev_ff <= in_sync_ff;
        end
    end
    assign in_rise = in_sync_ff & ~in_prev_ff;

    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            ms_cnt_ff <= '0;
            ms_tick_ff <= 1'b0;
        end else if (ms_cnt_ff == MSW'(MS_CYCLES - 1)) begin
            ms_cnt_ff <= '0;
            ms_tick_ff <= 1'b1;
        end else begin
            ms_cnt_ff <= ms_cnt_ff + MSW'(1);
            ms_tick_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            sec_ms_ff <= 10'h000;
            sec_tick_ff <= 1'b0;
        end else if (ms_tick_ff && sec_ms_ff == dwc_pkg::SEC_MS - 10'h001) begin
            sec_ms_ff <= 10'h000;
            sec_tick_ff <= 1'b1;
        end else begin
            sec_ms_ff <= ms_tick_ff ? sec_ms_ff + 10'h001 : sec_ms_ff;
            sec_tick_ff <= 1'b0;
        end
    end

    // Nonzero settings below the floor are raised to it
    assign wdt_limit = (wdt_timeout_s < dwc_pkg::WDT_MIN_S) ? dwc_pkg::WDT_MIN_S : wdt_timeout_s;
    assign wdt_fire = sec_tick_ff && !wdt_expired_ff && (wdt_timeout_s != dwc_pkg::WDT_OFF_S)
                      && (wdt_sec_ff + 16'h0001 >= wdt_limit) && !host_activity;

    // Host traffic restarts the count; expiry holds until traffic returns or the timeout is set to zero
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            wdt_sec_ff <= 16'h0000;
            wdt_expired_ff <= 1'b0;
        end else if (host_activity || wdt_timeout_s == dwc_pkg::WDT_OFF_S) begin
            wdt_sec_ff <= 16'h0000;
            wdt_expired_ff <= 1'b0;
        end else if (wdt_fire) begin
            wdt_expired_ff <= 1'b1;
        end else if (sec_tick_ff && !wdt_expired_ff) begin
            wdt_sec_ff <= wdt_sec_ff + 16'h0001;
        end
    end

    // Power-on pattern is caught by a clocked load after release, not by the reset
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            boot_done_ff <= 1'b0;
            out_base_ff <= 8'h00;
        end else if (!boot_done_ff) begin
            boot_done_ff <= 1'b1;
            out_base_ff <= power_on_value;
        end else if (out_write_stb) begin
            out_base_ff <= out_write_data;
        end else if (wdt_fire) begin
            out_base_ff <= safe_value;
        end
    end

    // Safe pattern overrides PWM while the watchdog has expired
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            out_ff <= 8'h00;
        end else if (wdt_expired_ff || wdt_fire) begin
            out_ff <= safe_value;
        end else if (!boot_done_ff) begin
            out_ff <= power_on_value;
        end else begin
            out_ff <= (pwm_enable & pwm_level) | (~pwm_enable & out_base_ff);
        end
    end

    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            clr_high_prev_ff <= 1'b0;
            clr_low_prev_ff <= 1'b0;
        end else begin
            clr_high_prev_ff <= latch_clr_high;
            clr_low_prev_ff <= latch_clr_low;
        end
    end
    assign clr_high_pulse = latch_clr_high & ~clr_high_prev_ff;
    assign clr_low_pulse = latch_clr_low & ~clr_low_prev_ff;

    assign win_len = (freq_scan_mode == dwc_pkg::DWC_SCAN_100) ? dwc_pkg::WIN_SHORT_MS : dwc_pkg::WIN_LONG_MS;
    assign win_scale = (freq_scan_mode == dwc_pkg::DWC_SCAN_100) ? dwc_pkg::SCALE_SHORT : dwc_pkg::SCALE_LONG;

    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            win_ms_ff <= 10'h000;
            win_end_ff <= 1'b0;
        end else if (ms_tick_ff && win_ms_ff + 10'h001 >= win_len) begin
            win_ms_ff <= 10'h000;
            win_end_ff <= 1'b1;
        end else begin
            win_ms_ff <= ms_tick_ff ? win_ms_ff + 10'h001 : win_ms_ff;
            win_end_ff <= 1'b0;
        end
    end

    for (genvar i = 0; i < NCH; i++) begin : g_ch
        logic [15:0] edge_cnt_ff;
        logic [16:0] period_ff;
        logic seen_ff;
        dwc_pkg::dwc_div_state_t div_state_ff;
        logic [17:0] rem_ff;
        logic [16:0] quo_ff;
        logic [16:0] dvs_ff;
        logic [4:0] bit_ff;
        logic [17:0] trial;
        logic sample_vld;
        logic [FW-1:0] sample;
        logic [FW-1:0] hist_ff [dwc_pkg::AVG_DEPTH];
        logic [FW+2:0] sum;
        logic [FW-1:0] avg_ff;
        logic pulse_mode;

        assign pulse_mode = (freq_scan_mode == dwc_pkg::DWC_SCAN_PULSE);

        dwc_in_chan u_in (
            .clk(clk),
            .rst_n(rst_n_s),
            .level(in_sync_ff[i]),
            .rise(in_rise[i]),
            .cnt_en(cnt_enable[i]),
            .cnt_clear(cnt_clear),
            .preset(cnt_preset[i*dwc_pkg::CW +: dwc_pkg::CW]),
            .latch_en(latch_enable),
            .clr_high(clr_high_pulse),
            .clr_low(clr_low_pulse),
            .count_ff(cnt_value[i*dwc_pkg::CW +: dwc_pkg::CW]),
            .latch_high_ff(latch_high[i]),
            .latch_low_ff(latch_low[i])
        );

        dwc_pwm_chan u_pwm (
            .clk(clk),
            .rst_n(rst_n_s),
            .ms_tick(ms_tick_ff),
            .enable(pwm_enable[i]),
            .high_ms(pwm_high_ms[i*16 +: 16]),
            .low_ms(pwm_low_ms[i*16 +: 16]),
            .level_ff(pwm_level[i])
        );

        // Edge count saturates rather than wrapping on out-of-range inputs
        always_ff @(posedge clk or negedge rst_n_s) begin
            if (!rst_n_s) begin
                edge_cnt_ff <= 16'h0000;
            end else if (win_end_ff) begin
                edge_cnt_ff <= {15'h0000, in_rise[i]};
            end else if (in_rise[i] && edge_cnt_ff != dwc_pkg::EDGE_MAX) begin
                edge_cnt_ff <= edge_cnt_ff + 16'h0001;
            end
        end

        // Period in ms between rising edges; reaching the limit means below 0.01 Hz and the count restarts from zero
        always_ff @(posedge clk or negedge rst_n_s) begin
            if (!rst_n_s) begin
                period_ff <= 17'h00000;
                seen_ff <= 1'b0;
            end else if (in_rise[i]) begin
                period_ff <= 17'h00000;
                seen_ff <= 1'b1;
            end else if (period_ff == dwc_pkg::PERIOD_MAX_MS) begin
                seen_ff <= 1'b0;
                period_ff <= ms_tick_ff ? 17'h00000 : period_ff;
            end else if (ms_tick_ff) begin
                period_ff <= period_ff + 17'h00001;
            end
        end

        assign trial = {rem_ff[16:0], dwc_pkg::PULSE_DIVIDEND[bit_ff]};

        // Restoring divider turns the period into hundredths of a hertz
        always_ff @(posedge clk or negedge rst_n_s) begin
            if (!rst_n_s) begin
                div_state_ff <= dwc_pkg::DWC_DIV_IDLE;
                rem_ff <= 18'h00000;
                quo_ff <= 17'h00000;
                dvs_ff <= 17'h00001;
                bit_ff <= 5'h00;
            end else begin
                case (div_state_ff)
                    dwc_pkg::DWC_DIV_IDLE: begin
                        if (pulse_mode && in_rise[i] && seen_ff) begin
                            div_state_ff <= dwc_pkg::DWC_DIV_RUN;
                            rem_ff <= 18'h00000;
                            quo_ff <= 17'h00000;
                            dvs_ff <= (period_ff == 17'h00000) ? 17'h00001 : period_ff;
                            bit_ff <= 5'h10;
                        end
                    end
                    dwc_pkg::DWC_DIV_RUN: begin
                        if (trial >= {1'b0, dvs_ff}) begin
                            rem_ff <= trial - {1'b0, dvs_ff};
                            quo_ff[bit_ff] <= 1'b1;
                        end else begin
                            rem_ff <= trial;
                        end
                        if (bit_ff == 5'h00) begin
                            div_state_ff <= dwc_pkg::DWC_DIV_IDLE;
                        end else begin
                            bit_ff <= bit_ff - 5'h01;
                        end
                    end
                    default: begin
                        div_state_ff <= dwc_pkg::DWC_DIV_IDLE;
                    end
                endcase
            end
        end

        // Every sample is in hundredths of a hertz whichever mode produced it
        always_comb begin
            sample_vld = 1'b0;
            sample = '0;
            if (freq_enable[i]) begin
                if (!pulse_mode && win_end_ff) begin
                    sample_vld = 1'b1;
                    sample = FW'(edge_cnt_ff) * FW'(win_scale);
                end else if (pulse_mode && div_state_ff == dwc_pkg::DWC_DIV_RUN && bit_ff == 5'h00) begin
                    sample_vld = 1'b1;
                    sample = (trial >= {1'b0, dvs_ff}) ? FW'(quo_ff | 17'h00001) : FW'(quo_ff);
                end else if (pulse_mode && seen_ff && period_ff == dwc_pkg::PERIOD_MAX_MS) begin
                    sample_vld = 1'b1;
                end
            end
        end

        always_ff @(posedge clk or negedge rst_n_s) begin
            if (!rst_n_s) begin
                for (int k = 0; k < dwc_pkg::AVG_DEPTH; k++) begin
                    hist_ff[k] <= '0;
                end
            end else if (sample_vld) begin
                hist_ff[0] <= sample;
                for (int k = 1; k < dwc_pkg::AVG_DEPTH; k++) begin
                    hist_ff[k] <= hist_ff[k-1];
                end
            end
        end

        always_comb begin
            sum = '0;
            for (int k = 0; k < dwc_pkg::AVG_DEPTH; k++) begin
                if (k < (1 << freq_avg_sel)) begin
                    sum = sum + (FW+3)'(hist_ff[k]);
                end
            end
        end

        always_ff @(posedge clk or negedge rst_n_s) begin
            if (!rst_n_s) begin
                avg_ff <= '0;
            end else if (!freq_enable[i]) begin
                avg_ff <= '0;
            end else begin
                avg_ff <= FW'(sum >> freq_avg_sel);
            end
        end

        assign freq_value[i*FW +: FW] = avg_ff;
    end

    assign output_channel = out_ff;
    assign wdt_expired = wdt_expired_ff;
endmodule

/* File: tb/dwc_field_model.sv */
`timescale 1ns/10ps
module dwc_field_model #(
    parameter int HALF = 4
) (
    // Clock
    input wire logic clk,
    // Stimulus control
    input wire logic [7:0] wave_en,
    input wire logic [7:0] base,
    // Field side
    output logic [7:0] input_channel,
    output logic [31:0] edge_count
);
    logic phase = 1'b0;
    int tick = 0;
    logic [31:0] edges_ff = 32'h00000000;

    // Pins move on the falling edge, half a cycle away from the design's sampling edge
    always @(negedge clk) begin
        if (wave_en == 8'h00) begin
            phase <= 1'b0;
            tick <= 0;
        end else if (tick == HALF - 1) begin
            tick <= 0;
            phase <= ~phase;
            if (!phase) edges_ff <= edges_ff + 32'h00000001;
        end else begin
            tick <= tick + 1;
        end
    end

    assign input_channel = (wave_en & {8{phase}}) | (~wave_en & base);
    assign edge_count = edges_ff;
endmodule

/* File: tb/dwc_top_chk.sv */
`timescale 1ns/10ps
module dwc_top_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Controls
    input wire logic host_activity,
    input wire logic [15:0] wdt_timeout_s,
    input wire logic [7:0] safe_value,
    input wire logic out_write_stb,
    input wire logic [7:0] out_write_data,
    input wire logic [7:0] cnt_enable,
    input wire logic cnt_clear,
    input wire logic [255:0] cnt_preset,
    input wire logic latch_enable,
    input wire logic latch_clr_high,
    input wire logic latch_clr_low,
    input wire logic [7:0] pwm_enable,
    // Observed outputs
    input wire logic [7:0] output_channel,
    input wire logic wdt_expired,
    input wire logic [255:0] cnt_value,
    input wire logic [7:0] latch_high,
    input wire logic [7:0] latch_low
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    write_path_a: assert property ((out_write_stb && pwm_enable == 8'h00 && !wdt_expired) ##1 !out_write_stb
        |-> ##2 (wdt_expired || output_channel == $past(out_write_data, 3))) else $error("write not seen");
    safe_out_a: assert property (wdt_expired |-> output_channel == safe_value)
        else $error("expired output not safe");
    wdt_off_a: assert property (wdt_timeout_s == 16'h0000 && !wdt_expired |=> !wdt_expired)
        else $error("disabled watchdog expired");
    wdt_clear_a: assert property (host_activity && wdt_expired |-> ##[1:2] !wdt_expired)
        else $error("expiry not cleared");
    cnt_clear_a: assert property (cnt_clear && cnt_enable == 8'h00 |=> ##[0:1] cnt_value == cnt_preset)
        else $error("clear did not load preset");
    cnt_hold_a: assert property ((!cnt_enable[0] && !cnt_clear) [*2] |=> $stable(cnt_value[31:0]))
        else $error("disabled counter moved");
    cnt_step_a: assert property (cnt_enable[1] && !cnt_clear |=>
        cnt_value[63:32] - $past(cnt_value[63:32]) <= 32'h00000001) else $error("counter jumped");
    latch_hi_clr_a: assert property ($rose(latch_clr_high) && !latch_enable |-> ##[1:3] latch_high == 8'h00)
        else $error("high latches kept");
    latch_lo_clr_a: assert property ($rose(latch_clr_low) && !latch_enable |-> ##[1:3] latch_low == 8'h00)
        else $error("low latches kept");

    cover property (wdt_expired);
    cover property (cnt_clear);
    cover property ($rose(latch_clr_high));
    cover property (pwm_enable[2] && $rose(output_channel[2]));
endmodule

bind dwc_top dwc_top_chk i_chk (.*);

/* File: tb/dwc_top_test.sv */
`timescale 1ns/10ps
module dwc_top_test;
    localparam int MSC = 4;
    localparam int SEC = 1000 * MSC;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic host_activity = 1'b0;
    logic [15:0] wdt_timeout_s = 16'h0000;
    logic [7:0] safe_value = 8'h00;
    logic [7:0] power_on_value = 8'h00;
    logic out_write_stb = 1'b0;
    logic [7:0] out_write_data = 8'h00;
    logic [7:0] cnt_enable = 8'h00;
    logic cnt_clear = 1'b0;
    logic [255:0] cnt_preset = 256'h0;
    logic latch_enable = 1'b0;
    logic latch_clr_high = 1'b0;
    logic latch_clr_low = 1'b0;
    logic [7:0] freq_enable = 8'h00;
    logic [1:0] freq_scan_mode = 2'h0;
    logic [1:0] freq_avg_sel = 2'h0;
    logic [7:0] pwm_enable = 8'h00;
    logic [127:0] pwm_high_ms = {8{16'h03E8}};
    logic [127:0] pwm_low_ms = {8{16'h03E8}};
    logic [7:0] input_channel;
    logic [7:0] output_channel;
    logic wdt_expired;
    logic [255:0] cnt_value;
    logic [159:0] freq_value;
    logic [7:0] latch_high;
    logic [7:0] latch_low;
    logic [7:0] wave_en = 8'h00;
    logic [7:0] field_base = 8'h00;
    logic [31:0] edges;
    logic [8:0] obs;
    logic [7:0] q [6];
    int fail_count = 0;
    int n_tests = 0;

    always #2.5 clk = ~clk;
    assign obs = {wdt_expired, output_channel};

    dwc_top #(.MS_CYCLES(MSC)) i_dut (.*);
    dwc_field_model i_field (.clk(clk), .wave_en(wave_en), .base(field_base), .input_channel(input_channel),
        .edge_count(edges));

    function automatic logic [31:0] exp_count(logic [31:0] p, logic [31:0] n, logic en);
        return en ? p + n : p;
    endfunction

    function automatic logic [31:0] freq_exp(int md);
        return (md ? 100 : 1000) * MSC / 8 * (md ? 1000 : 100);
    endfunction

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        n_tests++;
        if ($isunknown(got) || got < lo || got > hi) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h range=%h..%h", $time, got, lo, hi);
        end
    endtask

    // Bit 8 of obs is the expiry flag, the rest the output pins
    task automatic wait_bit(input int b, input logic v, input int lim, output int n);
        n = 0;
        while (obs[b] !== v) begin
            @(negedge clk);
            n++;
            if (n > lim) begin
                fail_count++;
                final_report();
            end
        end
    endtask

    initial begin
        int n;
        int w;
        int hi;
        n = $urandom(22);
        safe_value = 8'($urandom);
        power_on_value = 8'($urandom);
        for (int i = 0; i < 6; i++) q[i] = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        chk8(output_channel, power_on_value);
        for (int i = 0; i < 8; i++) begin
            out_write_stb = (i < 6);
            if (i < 6) out_write_data = q[i];
            @(negedge clk);
            if (i >= 1) chk8(output_channel, q[(i < 6) ? i - 1 : 5]);
        end
        for (int i = 0; i < 8; i++) cnt_preset[32*i +: 32] = $urandom;
        cnt_preset[63:32] = 32'hFFFFFFFE;
        cnt_clear = 1'b1;
        @(negedge clk);
        cnt_clear = 1'b0;
        repeat (2) @(negedge clk);
        for (int i = 0; i < 8; i++) chk32(cnt_value[32*i +: 32], cnt_preset[32*i +: 32]);
        cnt_enable = {6'($urandom), 2'b10};
        wave_en = 8'hFF;
        repeat (90) @(negedge clk);
        wave_en = 8'h00;
        repeat (8) @(negedge clk);
        for (int i = 0; i < 8; i++)
            chk32(cnt_value[32*i +: 32], exp_count(cnt_preset[32*i +: 32], edges, cnt_enable[i]));
        field_base = 8'hFF;
        repeat (6) @(negedge clk);
        chk8(latch_high, 8'h00);
        latch_enable = 1'b1;
        repeat (6) @(negedge clk);
        field_base = 8'h00;
        repeat (6) @(negedge clk);
        latch_enable = 1'b0;
        chk8(latch_high & latch_low, 8'hFF);
        latch_clr_high = 1'b1;
        repeat (4) @(negedge clk);
        chk8(latch_high, 8'h00);
        chk8(latch_low, 8'hFF);
        latch_clr_low = 1'b1;
        repeat (4) @(negedge clk);
        chk8(latch_low, 8'h00);
        latch_clr_high = 1'b0;
        latch_clr_low = 1'b0;
        freq_enable = 8'h01;
        wave_en = 8'h01;
        for (int md = 0; md < 3; md++) begin
            freq_scan_mode = 2'(md);
            freq_avg_sel = md ? 2'($urandom) : 2'h0;
            w = (md ? 100 : 1000) * MSC;
            repeat (((1 << freq_avg_sel) + 2) * w) @(negedge clk);
            chk_rng({12'h000, freq_value[19:0]}, freq_exp(md) - (md ? 1000 : 100),
                freq_exp(md) + (md ? 1000 : 100));
        end
        wave_en = 8'h00;
        hi = 5 + $urandom % 5;
        pwm_high_ms[47:32] = 16'(hi);
        pwm_low_ms[47:32] = 16'h0002;
        pwm_enable = 8'h04;
        wait_bit(2, 1'b1, 200, n);
        wait_bit(2, 1'b0, 200, n);
        wait_bit(2, 1'b1, 200, n);
        chk_rng(n, 5 * MSC - 1, 5 * MSC + 1);
        wait_bit(2, 1'b0, 200, n);
        chk_rng(n, hi * MSC - 1, hi * MSC + 1);
        pwm_enable = 8'h00;
        chk8({7'h00, wdt_expired}, 8'h00);
        host_activity = 1'b1;
        wdt_timeout_s = 16'h0005;
        @(negedge clk);
        host_activity = 1'b0;
        wait_bit(8, 1'b1, 6 * SEC, n);
        chk_rng(n, 4 * SEC - 2, 5 * SEC + 2);
        chk8(output_channel, safe_value);
        host_activity = 1'b1;
        @(negedge clk);
        host_activity = 1'b0;
        repeat (2) @(negedge clk);
        chk8({7'h00, wdt_expired}, 8'h00);
        final_report();
    end
endmodule
